/* File: design/cpf_cfg.svh */
/*
 * Constants for the codec port frame configuration registers.
 * Assumes an 8-bit memory-mapped data bus from the on-chip microcontroller
 * with a 16-bit address; included by bare name.
 */
`ifndef CPF_CFG_SVH
`define CPF_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CPF_ADDR_SLOT_FORMAT   16'hffdf
`define CPF_ADDR_MODE_COUNT    16'hffe0
`define CPF_RESET_VALUE        8'h00
`define CPF_NUM_REGS           10
`define CPF_NUM_CFG_REGS       4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CPF_COUNT_MSB          7
`define CPF_COUNT_LSB          3
`define CPF_MODE_MSB           2
`define CPF_MODE_LSB           0
`define CPF_FIRST_MSB          7
`define CPF_FIRST_LSB          6
`define CPF_BITS_MSB           5
`define CPF_BITS_LSB           3
`define CPF_SLEN_MSB           2
`define CPF_SLEN_LSB           0

`endif

/* File: design/cpf_pkg.sv */
/*
 * Types for the codec port frame configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpf_pkg;

    typedef enum logic [2:0] {
        CPF_MODE_GENERAL  = 3'h0,
        CPF_MODE_VENDOR   = 3'h1,
        CPF_MODE_AC97_V1  = 3'h2,
        CPF_MODE_AC97_V2  = 3'h3,
        CPF_MODE_I2S_SAME = 3'h4,
        CPF_MODE_I2S_DIFF = 3'h5,
        CPF_MODE_RSVD6    = 3'h6,
        CPF_MODE_RSVD7    = 3'h7
    } cpf_mode_e;

    typedef logic [5:0] cpf_len_t;

endpackage

/* File: design/cpf_decode.sv */
/*
 * Decodes the stored frame format into widths and flags.
 * Assumes register contents arrive from flip-flops on the same clock.
 */
`timescale 1ns/1ns
`include "cpf_cfg.svh"

module cpf_decode (
    // Stored fields
    input  wire logic [7:0]       mode_count,
    input  wire logic [7:0]       slot_format,
    // Decoded format
    output cpf_pkg::cpf_mode_e    mode,
    output logic                  mode_rsvd,
    output logic [5:0]            slot_total,
    output logic                  count_illegal,
    output cpf_pkg::cpf_len_t     audio_bits,
    output logic                  bits_rsvd,
    output cpf_pkg::cpf_len_t     other_len,
    output logic                  other_rsvd,
    output cpf_pkg::cpf_len_t     first_len,
    output logic                  first_rsvd
);

    // Slot-length code to cycles; used for both slot length and audio bits
    function automatic cpf_pkg::cpf_len_t len_of(input logic [2:0] code);
        unique case (code)
            3'h0: len_of = 6'h08;
            3'h1: len_of = 6'h10;
            3'h2: len_of = 6'h12;
            3'h3: len_of = 6'h14;
            3'h4: len_of = 6'h18;
            3'h5: len_of = 6'h20;
            default: len_of = 6'h00;
        endcase
    endfunction

    logic [4:0] count_f;
    logic [2:0] slen_f;
    logic [2:0] bits_f;
    logic [1:0] first_f;

    assign count_f = mode_count[`CPF_COUNT_MSB:`CPF_COUNT_LSB];
    assign slen_f  = slot_format[`CPF_SLEN_MSB:`CPF_SLEN_LSB];
    assign bits_f  = slot_format[`CPF_BITS_MSB:`CPF_BITS_LSB];
    assign first_f = slot_format[`CPF_FIRST_MSB:`CPF_FIRST_LSB];

    assign mode          = cpf_pkg::cpf_mode_e'(mode_count[`CPF_MODE_MSB:`CPF_MODE_LSB]);
    assign mode_rsvd     = mode_count[`CPF_MODE_MSB:`CPF_MODE_LSB+1] == 2'h3;
    assign slot_total    = {1'b0, count_f} + 6'h01;
    assign count_illegal = count_f == 5'h00;
    assign audio_bits    = len_of(bits_f);
    assign bits_rsvd     = bits_f[2:1] == 2'h3;
    assign other_len     = (slen_f > 3'h4) ? 6'h00 : len_of(slen_f);
    assign other_rsvd    = slen_f > 3'h4;

    always_comb begin
        unique case (first_f)
            2'h0: first_len = other_len;
            2'h1: first_len = 6'h08;
            2'h2: first_len = 6'h10;
            2'h3: first_len = 6'h00;
        endcase
        first_rsvd = first_f == 2'h3;
    end

endmodule // cpf_decode

/* File: design/cpf_frame_config.sv */
/*
 * Codec port frame configuration registers on the microcontroller bus.
 * Assumes a single-cycle 8-bit bus: address, write strobe, write data,
 * read data combinational on address. Port enable comes from the global
 * control register on the same clock.
 */
`timescale 1ns/1ns
`include "cpf_cfg.svh"

module cpf_frame_config (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RST_N,
    // Microcontroller bus
    input  wire logic [15:0]      ADDR,
    input  wire logic             WR,
    input  wire logic [7:0]       WDATA,
    output logic [7:0]            RDATA,
    output logic                  HIT,
    // Global control
    input  wire logic             SERIAL_PORT_ENABLE,
    // Decoded format
    output cpf_pkg::cpf_mode_e    MODE,
    output logic                  MODE_RESERVED,
    output logic [5:0]            SLOT_COUNT,
    output logic                  SLOT_COUNT_ILLEGAL,
    output cpf_pkg::cpf_len_t     AUDIO_BITS_PER_SLOT,
    output logic                  AUDIO_BITS_RESERVED,
    output cpf_pkg::cpf_len_t     SLOT_LENGTH,
    output logic                  SLOT_LENGTH_RESERVED,
    output cpf_pkg::cpf_len_t     FIRST_SLOT_LENGTH,
    output logic                  FIRST_SLOT_RESERVED
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] mode_count_q;
    logic [7:0] slot_format_q;
    logic       sel_mode;
    logic       sel_format;
    logic       wr_ok;

    assign sel_mode   = ADDR == `CPF_ADDR_MODE_COUNT;
    assign sel_format = ADDR == `CPF_ADDR_SLOT_FORMAT;
    assign wr_ok      = WR && !SERIAL_PORT_ENABLE;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mode_count_q <= `CPF_RESET_VALUE;
        end else if (wr_ok && sel_mode) begin
            mode_count_q <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            slot_format_q <= `CPF_RESET_VALUE;
        end else if (wr_ok && sel_format) begin
            slot_format_q <= WDATA;
        end
    end

    // Read back; unmapped addresses return zero with HIT low
    assign HIT   = sel_mode || sel_format;
    assign RDATA = sel_mode ? mode_count_q : (sel_format ? slot_format_q : 8'h00);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    cpf_decode u_decode (
        .mode_count    (mode_count_q),
        .slot_format   (slot_format_q),
        .mode          (MODE),
        .mode_rsvd     (MODE_RESERVED),
        .slot_total    (SLOT_COUNT),
        .count_illegal (SLOT_COUNT_ILLEGAL),
        .audio_bits    (AUDIO_BITS_PER_SLOT),
        .bits_rsvd     (AUDIO_BITS_RESERVED),
        .other_len     (SLOT_LENGTH),
        .other_rsvd    (SLOT_LENGTH_RESERVED),
        .first_len     (FIRST_SLOT_LENGTH),
        .first_rsvd    (FIRST_SLOT_RESERVED)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_locked_while_enabled: assert property (@(posedge CLK) disable iff (!RST_N)
        SERIAL_PORT_ENABLE |=> $stable(mode_count_q) && $stable(slot_format_q))
        else $error("config changed while port enabled");
    chk_write_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        WR && !SERIAL_PORT_ENABLE && sel_mode |=> mode_count_q == $past(WDATA))
        else $error("mode register write lost");
    chk_format_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        WR && !SERIAL_PORT_ENABLE && sel_format |=> slot_format_q == $past(WDATA))
        else $error("format register write lost");
    chk_slot_count_val: assert property (@(posedge CLK) disable iff (!RST_N)
        SLOT_COUNT == {1'b0, mode_count_q[7:3]} + 6'h01)
        else $error("slot count wrong");
    chk_mode_reserved: assert property (@(posedge CLK) disable iff (!RST_N)
        MODE_RESERVED == (mode_count_q[2:0] >= 3'h6))
        else $error("reserved mode flag wrong");
    chk_i2s_modes: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[2:1] == 2'h2 |-> (MODE == cpf_pkg::CPF_MODE_I2S_SAME
            || MODE == cpf_pkg::CPF_MODE_I2S_DIFF))
        else $error("I2S mode decode wrong");
    chk_audio_bits: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[5:3] == 3'h5 |-> AUDIO_BITS_PER_SLOT == 6'h20)
        else $error("audio bits decode wrong");
    chk_first_same: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[7:6] == 2'h0 |-> FIRST_SLOT_LENGTH == SLOT_LENGTH)
        else $error("first slot length not following others");
    chk_slot_len: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[2:0] == 3'h2 |-> SLOT_LENGTH == 6'h12)
        else $error("slot length decode wrong");
    chk_bits_indep: assert property (@(posedge CLK) disable iff (!RST_N)
        $stable(slot_format_q[2:0]) && $stable(slot_format_q[7:6]) |-> $stable(SLOT_LENGTH))
        else $error("slot length moved with audio bits");

    // ------------------------------------------------------------------
    // Reset, write gating and read back
    // ------------------------------------------------------------------
    chk_reset_mode: assert property (@(posedge CLK)
        !RST_N |=> mode_count_q == `CPF_RESET_VALUE)
        else $error("mode register not cleared by reset");
    chk_reset_format: assert property (@(posedge CLK)
        !RST_N |=> slot_format_q == `CPF_RESET_VALUE)
        else $error("format register not cleared by reset");
    chk_unmapped_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
        WR && !HIT |=> $stable(mode_count_q) && $stable(slot_format_q))
        else $error("unmapped write changed a register");
    chk_idle_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        !WR |=> $stable(mode_count_q) && $stable(slot_format_q))
        else $error("register changed without a write");
    chk_read_mode: assert property (@(posedge CLK) disable iff (!RST_N)
        sel_mode |-> RDATA == mode_count_q)
        else $error("mode register read back wrong");
    chk_read_format: assert property (@(posedge CLK) disable iff (!RST_N)
        sel_format |-> RDATA == slot_format_q)
        else $error("format register read back wrong");
    chk_read_unmapped: assert property (@(posedge CLK) disable iff (!RST_N)
        !HIT |-> RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_hit_map: assert property (@(posedge CLK) disable iff (!RST_N)
        HIT == (ADDR == `CPF_ADDR_MODE_COUNT || ADDR == `CPF_ADDR_SLOT_FORMAT))
        else $error("address match wrong");

    // ------------------------------------------------------------------
    // Slot count and mode
    // ------------------------------------------------------------------
    chk_count_illegal: assert property (@(posedge CLK) disable iff (!RST_N)
        SLOT_COUNT_ILLEGAL == (mode_count_q[`CPF_COUNT_MSB:`CPF_COUNT_LSB] == 5'h00))
        else $error("illegal slot count flag wrong");
    chk_count_two: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[7:3] == 5'h01 |-> SLOT_COUNT == 6'h02)
        else $error("two slot frame wrong");
    chk_count_max: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[7:3] == 5'h0d |-> SLOT_COUNT == 6'h0e)
        else $error("fourteen slot frame wrong");
    chk_mode_general: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[2:0] == 3'h0 |-> MODE == cpf_pkg::CPF_MODE_GENERAL)
        else $error("general mode decode wrong");
    chk_mode_vendor: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[2:0] == 3'h1 |-> MODE == cpf_pkg::CPF_MODE_VENDOR)
        else $error("vendor codec mode decode wrong");
    chk_mode_ac97_v1: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[2:0] == 3'h2 |-> MODE == cpf_pkg::CPF_MODE_AC97_V1)
        else $error("first AC97 mode decode wrong");
    chk_mode_ac97_v2: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[2:0] == 3'h3 |-> MODE == cpf_pkg::CPF_MODE_AC97_V2)
        else $error("second AC97 mode decode wrong");
    chk_mode_i2s_same: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[2:0] == 3'h4 |-> MODE == cpf_pkg::CPF_MODE_I2S_SAME)
        else $error("I2S same rate decode wrong");
    chk_mode_i2s_diff: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_count_q[2:0] == 3'h5 |-> MODE == cpf_pkg::CPF_MODE_I2S_DIFF)
        else $error("I2S split rate decode wrong");

    // ------------------------------------------------------------------
    // Audio bits per slot
    // ------------------------------------------------------------------
    chk_bits_8: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[5:3] == 3'h0 |-> AUDIO_BITS_PER_SLOT == 6'h08)
        else $error("8 bit audio decode wrong");
    chk_bits_16: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[5:3] == 3'h1 |-> AUDIO_BITS_PER_SLOT == 6'h10)
        else $error("16 bit audio decode wrong");
    chk_bits_18: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[5:3] == 3'h2 |-> AUDIO_BITS_PER_SLOT == 6'h12)
        else $error("18 bit audio decode wrong");
    chk_bits_20: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[5:3] == 3'h3 |-> AUDIO_BITS_PER_SLOT == 6'h14)
        else $error("20 bit audio decode wrong");
    chk_bits_24: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[5:3] == 3'h4 |-> AUDIO_BITS_PER_SLOT == 6'h18)
        else $error("24 bit audio decode wrong");
    chk_bits_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[5:3] >= 3'h6 |-> AUDIO_BITS_RESERVED && AUDIO_BITS_PER_SLOT == 6'h00)
        else $error("reserved audio width not flagged");
    chk_bits_legal: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[5:3] < 3'h6 |-> !AUDIO_BITS_RESERVED)
        else $error("legal audio width flagged reserved");

    // ------------------------------------------------------------------
    // Slot lengths
    // ------------------------------------------------------------------
    chk_len_8: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[2:0] == 3'h0 |-> SLOT_LENGTH == 6'h08)
        else $error("8 cycle slot decode wrong");
    chk_len_16: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[2:0] == 3'h1 |-> SLOT_LENGTH == 6'h10)
        else $error("16 cycle slot decode wrong");
    chk_len_20: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[2:0] == 3'h3 |-> SLOT_LENGTH == 6'h14)
        else $error("20 cycle slot decode wrong");
    chk_len_24: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[2:0] == 3'h4 |-> SLOT_LENGTH == 6'h18)
        else $error("24 cycle slot decode wrong");
    chk_len_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[2:0] > 3'h4 |-> SLOT_LENGTH_RESERVED && SLOT_LENGTH == 6'h00)
        else $error("reserved slot length not flagged");
    chk_len_legal: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[2:0] <= 3'h4 |-> !SLOT_LENGTH_RESERVED)
        else $error("legal slot length flagged reserved");
    chk_first_8: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[7:6] == 2'h1 |-> FIRST_SLOT_LENGTH == 6'h08)
        else $error("8 cycle first slot wrong");
    chk_first_16: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[7:6] == 2'h2 |-> FIRST_SLOT_LENGTH == 6'h10)
        else $error("16 cycle first slot wrong");
    chk_first_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[7:6] == 2'h3 |-> FIRST_SLOT_RESERVED && FIRST_SLOT_LENGTH == 6'h00)
        else $error("reserved first slot code not flagged");
    chk_first_legal: assert property (@(posedge CLK) disable iff (!RST_N)
        slot_format_q[7:6] != 2'h3 |-> !FIRST_SLOT_RESERVED)
        else $error("legal first slot code flagged reserved");

    cov_write_open:    cover property (@(posedge CLK) WR && !SERIAL_PORT_ENABLE && sel_mode);
    cov_write_blocked: cover property (@(posedge CLK) WR && SERIAL_PORT_ENABLE && HIT);
    cov_i2s_diff:      cover property (@(posedge CLK) MODE == cpf_pkg::CPF_MODE_I2S_DIFF);
    cov_mode_reserved: cover property (@(posedge CLK) MODE_RESERVED);
    cov_write_miss:    cover property (@(posedge CLK) WR && !SERIAL_PORT_ENABLE && !HIT);

endmodule // cpf_frame_config

/* File: bench/cpf_glob_ctl.sv */
/*
 * Global control model holding the serial port enable bit.
 * Assumes one-cycle set and clear pulses from the bench on CLK.
 */
`timescale 1ns/1ns
module cpf_glob_ctl (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST_N,
    // Control
    input  wire logic SET,
    input  wire logic CLR,
    output logic      EN
);
    always_ff @(posedge CLK) begin
        if (!RST_N) EN <= 1'b0;
        else if (SET) EN <= 1'b1;
        else if (CLR) EN <= 1'b0;
    end
endmodule // cpf_glob_ctl

/* File: bench/cpf_frame_config_tb_top.sv */
/*
 * Self-checking bench for the frame configuration registers.
 * Assumes the design and cpf_glob_ctl are compiled before it.
 */
`timescale 1ns/1ns
`include "cpf_cfg.svh"
module cpf_frame_config_tb_top;
    logic clk = 0, rst_n = 0, wr_en = 0, set = 0, clr = 0, look = 0, en, hit;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata, m_mc = 8'h00, m_sf = 8'h00;
    logic mrs, sill, abr, slr, flr;
    logic [5:0] scnt;
    cpf_pkg::cpf_mode_e mode;
    cpf_pkg::cpf_len_t  ab, sl, fl;
    logic [40:0] q[$];
    logic [5:0] ab_t[8] = '{6'h08, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20, 6'h00, 6'h00};
    logic [5:0] sl_t[8] = '{6'h08, 6'h10, 6'h12, 6'h14, 6'h18, 6'h00, 6'h00, 6'h00};
    int n_fail = 0, cmp_count = 0;
    integer seed = 32'hf538_4e35, r;
    localparam logic [15:0] MC = `CPF_ADDR_MODE_COUNT;
    localparam logic [15:0] SF = `CPF_ADDR_SLOT_FORMAT;

    cpf_frame_config DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR(wr_en), .WDATA(wdata),
        .RDATA(rdata), .HIT(hit), .SERIAL_PORT_ENABLE(en), .MODE(mode), .MODE_RESERVED(mrs),
        .SLOT_COUNT(scnt), .SLOT_COUNT_ILLEGAL(sill), .AUDIO_BITS_PER_SLOT(ab),
        .AUDIO_BITS_RESERVED(abr), .SLOT_LENGTH(sl), .SLOT_LENGTH_RESERVED(slr),
        .FIRST_SLOT_LENGTH(fl), .FIRST_SLOT_RESERVED(flr));
    cpf_glob_ctl u_ctl (.CLK(clk), .RST_N(rst_n), .SET(set), .CLR(clr), .EN(en));

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // Expected outputs from shadow registers
    // ------------------------------------------------------------
    function automatic logic [40:0] expv(input logic [15:0] a);
        logic [5:0] f;
        logic [7:0] rd;
        f = (m_sf[7:6] == 2'h0) ? sl_t[m_sf[2:0]] : (m_sf[7:6] == 2'h1) ? 6'h08 :
            (m_sf[7:6] == 2'h2) ? 6'h10 : 6'h00;
        rd = (a == MC) ? m_mc : (a == SF) ? m_sf : 8'h00;
        return {(a == MC) || (a == SF), rd, m_mc[2:0], m_mc[2:1] == 2'h3,
                {1'b0, m_mc[7:3]} + 6'h01, m_mc[7:3] == 5'h00, ab_t[m_sf[5:3]],
                m_sf[5:4] == 2'h3, sl_t[m_sf[2:0]], m_sf[2:0] > 3'h4, f, m_sf[7:6] == 2'h3};
    endfunction

    task automatic check(input logic [40:0] got, input logic [40:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_en <= 1'b1;
        wdata <= d;
        if (!en && a == MC) m_mc = d;
        if (!en && a == SF) m_sf = d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic see(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        q.push_back(expv(a));
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask

    task automatic pulse(input logic s);
        @(posedge clk);
        set <= s;
        clr <= !s;
        @(posedge clk);
        set <= 1'b0;
        clr <= 1'b0;
    endtask

    task automatic give_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (look) begin
            if (q.size() == 0) check(41'h0, 41'h1);
            else check({hit, rdata, mode, mrs, scnt, sill, ab, abr, sl, slr, fl, flr},
                       q.pop_front());
        end
    end

    initial begin
        repeat (2000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        see(MC);
        see(SF);
        see(16'h1234);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            wr(MC, {(5'(r[3:0]) % 5'h0d) + 5'h01, i[2:0]});
            see(MC);
            wr(SF, {r[7:6], i[2:0], r[2:0]});
            see(SF);
            wr(SF, {i[1:0], r[5:3], i[2:0]});
            see(SF);
        end
        pulse(1'b1);
        wr(MC, 8'h6c);
        wr(SF, 8'hff);
        see(MC);
        see(SF);
        pulse(1'b0);
        wr(16'hffe1, 8'haa);
        wr(MC, 8'h6c);
        wr(SF, 8'h24);
        see(MC);
        see(SF);
        give_verdict();
    end
endmodule // cpf_frame_config_tb_top
